// file: logic/cisc_setup.v
// Purpose: settings and command handling for counter input conditioning and gating
// Assumes: controller sends decoded commands, one per cmd_valid pulse, values pre-scaled
//          (level as a signed micro-volt integer, gate in microseconds)
// Notes: query answers come one cycle after the command, error pop answers two cycles after; error codes are queued
// What this block does
// R1: averaging count query answers fixed 100; nothing changes it
// R2: separate absolute trigger level per input one and two, +-10.2375 V, 2.5 mV
// R3: out-of-span level is clipped to the limit and posts error -209
// R4: level is truncated to a whole 2.5 mV step before storing
// R5: writing absolute level clears peak tracking and stores the level
// R6: reset sets both absolute levels to zero volts
// R7: tracked level is negative peak plus fraction percent of peak-to-peak
// R8: peak detection and level computing happen only when a measurement starts
// R9: single shot find derives level for exactly one following measurement
// R10: auto state reads 1 when on, 0 when off or single shot chosen
// R11: fraction accepts 10 to 90 percent, min/max limits, default 50
// R12: per-input edge choice stored, reported, rising at reset
// R13: an event counts only when signal passes both noise band limits
// R14: three noise bands 30, 60, 100 mV; query returns the chosen name
// R15: gate duration in 1 ms steps, 1 ms to 99.999 s, truncated, reset 100 ms
// R16: out-of-span gate duration takes nearer limit and posts error -209
// R17: gate duration is a minimum; gate stays open to align with periods
// R18: gate query returns ms value, or min, max, default when asked
// R19: with self select, divide-by-2 prescaler on input one above 100 MHz only
// R20: manual range selection clears prescale self select
// R21: automatic range applies only to frequency, period and ratio
// R22: posted error codes are queued and read back in order
`timescale 1ns/100ps
`default_nettype none
`include "cisc_consts.vh"
module cisc_setup #(
    parameter ERR_DEPTH_LOG2 = 3, // error queue depth as a power of two
    parameter PEAK_W = 13 // width of peak samples in level steps
) (
    input wire clk, // instrument clock, 250 MHz
    input wire reset_n, // async reset, active low
    input wire cmd_valid, // one-cycle command strobe
    input wire [3:0] cmd_op, // command opcode
    input wire cmd_input, // 0 selects input one, 1 input two
    input wire [3:0] cmd_item, // query item
    input wire [1:0] cmd_qual, // query qualifier cur/min/max/def
    input wire [31:0] cmd_value, // signed value: level in uV, gate in us, other codes
    output reg rsp_valid, // one-cycle answer strobe
    output reg [31:0] rsp_value, // answer: level steps, percent, ms, codes
    output wire err_empty, // error queue is empty
    output wire err_overflow, // an error code was lost
    input wire meas_start, // measurement initiated, one-cycle pulse
    input wire meas_func_fpr, // function is frequency, period or ratio
    input wire signed [PEAK_W-1:0] peak_neg, // detected negative peak, input selected by meas_input
    input wire signed [PEAK_W-1:0] peak_pos, // detected positive peak
    input wire meas_input, // input being measured
    input wire [27:0] input_freq_hz, // measured frequency of input one
    output reg signed [12:0] level_one, // applied trigger level, input one
    output reg signed [12:0] level_two, // applied trigger level, input two
    output reg slope_falling_one, // input one uses falling edge
    output reg slope_falling_two, // input two uses falling edge
    output reg [7:0] band_mv_one, // noise band width, input one
    output reg [7:0] band_mv_two, // noise band width, input two
    output reg [16:0] gate_ms, // minimum gate duration in ms
    output reg prescale_on // divide-by-2 on input one engaged
);
    // stored settings, per input except range_auto
    reg signed [12:0] abs_level [0:1];
    reg [1:0] auto_mode [0:1];
    reg single_shot_level_find_armed [0:1];
    reg [6:0] frac [0:1];
    reg falling [0:1];
    reg [1:0] band [0:1];
    reg range_auto;
    reg err_push;
    wire [15:0] err_code;

    // level request: signed uV to steps, truncate toward zero, then clip
    wire signed [31:0] lvl_req = cmd_value;
    wire signed [31:0] lvl_steps = lvl_req / `CISC_LEVEL_STEP_UV; // [R4]
    wire lvl_hi = lvl_steps > 32'sd4095;
    wire lvl_lo = lvl_steps < -32'sd4095;
    wire signed [12:0] lvl_clip = lvl_hi ? `CISC_LEVEL_MAX :
                                  lvl_lo ? `CISC_LEVEL_MIN : lvl_steps[12:0]; // [R3]

    // gate request: us to ms with truncation, then clip to span
    wire [31:0] gate_req_ms = cmd_value / 32'd1000; // [R15]
    wire gate_hi = cmd_value[31] ? 1'b0 : (gate_req_ms > {15'h0000, `CISC_GATE_MAX});
    wire gate_lo = cmd_value[31] || (gate_req_ms < {15'h0000, `CISC_GATE_MIN});
    wire [16:0] gate_clip = gate_hi ? `CISC_GATE_MAX :
                            gate_lo ? `CISC_GATE_MIN : gate_req_ms[16:0]; // [R16]

    // fraction request clipped to 10..90 percent
    wire [6:0] frac_clip = (cmd_value > 32'd90) ? `CISC_FRAC_MAX :
                           (cmd_value < 32'd10) ? `CISC_FRAC_MIN : cmd_value[6:0]; // [R11]

    wire is_set = cmd_valid && (cmd_op != `CISC_OP_QUERY) && (cmd_op != `CISC_OP_POP_ERR);
    wire sel = cmd_input;

    // tracked level: neg + frac% of (pos - neg); computed only at meas start
    wire signed [PEAK_W:0] pk_span = {peak_pos[PEAK_W-1], peak_pos} - {peak_neg[PEAK_W-1], peak_neg};
    wire signed [PEAK_W+8:0] pk_prod = pk_span * $signed({1'b0, frac[meas_input]});
    wire signed [PEAK_W+8:0] pk_pct = pk_prod / 22'sd100;
    wire signed [PEAK_W+8:0] pk_lvl = pk_pct + {{9{peak_neg[PEAK_W-1]}}, peak_neg}; // [R7]
    wire signed [12:0] pk_lvl13 = pk_lvl[12:0];
    wire track_now = meas_start && ((auto_mode[meas_input] == `CISC_AUTO_ON) ||
                                    single_shot_level_find_armed[meas_input]); // [R8]

    // settings storage
    integer i;
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            for (i = 0; i < 2; i = i + 1) begin
                abs_level[i] <= `CISC_LEVEL_DEF; // [R6]
                auto_mode[i] <= `CISC_AUTO_OFF;
                single_shot_level_find_armed[i] <= 1'b0;
                frac[i] <= `CISC_FRAC_DEF; // [R11]
                falling[i] <= 1'b0; // [R12]
                band[i] <= `CISC_BAND_DEF;
            end
            range_auto <= 1'b0;
            gate_ms <= `CISC_GATE_DEF; // [R15]
        end else begin
            // level tracking at measurement start; single shot used up here
            if (track_now) begin
                abs_level[meas_input] <= pk_lvl13; // [R7]
                if (single_shot_level_find_armed[meas_input]) begin
                    single_shot_level_find_armed[meas_input] <= 1'b0; // [R9]
                end
            end
            if (is_set) begin
                case (cmd_op)
                    `CISC_OP_SET_LEVEL: begin
                        abs_level[sel] <= lvl_clip; // [R2]
                        auto_mode[sel] <= `CISC_AUTO_OFF; // [R5]
                        single_shot_level_find_armed[sel] <= 1'b0; // [R5]
                    end
                    `CISC_OP_SET_AUTO: begin
                        auto_mode[sel] <= cmd_value[1:0] == `CISC_AUTO_SINGLE_SHOT_LEVEL_FIND ? `CISC_AUTO_SINGLE_SHOT_LEVEL_FIND :
                                          (cmd_value[0] ? `CISC_AUTO_ON : `CISC_AUTO_OFF);
                        single_shot_level_find_armed[sel] <= cmd_value[1:0] == `CISC_AUTO_SINGLE_SHOT_LEVEL_FIND; // [R9]
                    end
                    `CISC_OP_SET_FRAC: frac[sel] <= frac_clip; // [R11]
                    `CISC_OP_SET_SLOPE: falling[sel] <= cmd_value[0]; // [R12]
                    `CISC_OP_SET_BAND: begin
                        band[sel] <= (cmd_value[1:0] == 2'h3) ? `CISC_BAND_DEF : cmd_value[1:0]; // [R14]
                    end
                    `CISC_OP_SET_GATE: gate_ms <= gate_clip; // [R15]
                    `CISC_OP_SET_RAUTO: begin
                        if (!sel) begin
                            range_auto <= cmd_value[0]; // input two has no prescaler
                        end
                    end
                    `CISC_OP_SET_RANGE: range_auto <= 1'b0; // [R20]
                    default: begin
                    end
                endcase
            end
        end
    end

    // error posting: clipped level or gate posts -209
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            err_push <= 1'b0;
        end else begin
            err_push <= cmd_valid && (((cmd_op == `CISC_OP_SET_LEVEL) && (lvl_hi || lvl_lo)) ||
                                      ((cmd_op == `CISC_OP_SET_GATE) && (gate_hi || gate_lo))); // [R3] [R16]
        end
    end

    cisc_err_queue #(
        .DEPTH_LOG2(ERR_DEPTH_LOG2)
    ) u_err (
        .clk(clk),
        .reset_n(reset_n),
        .push(err_push),
        .push_code(`CISC_ERR_CLIPPED),
        .pop(cmd_valid && (cmd_op == `CISC_OP_POP_ERR)), // [R22]
        .pop_code(err_code),
        .empty(err_empty),
        .overflow(err_overflow)
    );

    // query answers; error pop answer follows from the queue register
    reg pop_pending;
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rsp_valid <= 1'b0;
            rsp_value <= 32'h00000000;
            pop_pending <= 1'b0;
        end else begin
            rsp_valid <= 1'b0;
            pop_pending <= cmd_valid && (cmd_op == `CISC_OP_POP_ERR);
            if (pop_pending) begin
                rsp_valid <= 1'b1;
                rsp_value <= {{16{err_code[15]}}, err_code}; // [R22]
            end else if (cmd_valid && (cmd_op == `CISC_OP_QUERY)) begin
                rsp_valid <= 1'b1;
                case (cmd_item)
                    `CISC_Q_LEVEL: begin
                        case (cmd_qual)
                            `CISC_QUAL_MIN: rsp_value <= {{19{1'b1}}, `CISC_LEVEL_MIN};
                            `CISC_QUAL_MAX: rsp_value <= {19'h00000, `CISC_LEVEL_MAX};
                            `CISC_QUAL_DEF: rsp_value <= 32'h00000000;
                            default: rsp_value <= {{19{abs_level[sel][12]}}, abs_level[sel]}; // [R2]
                        endcase
                    end
                    `CISC_Q_AUTO: rsp_value <= {31'h00000000,
                                                auto_mode[sel] == `CISC_AUTO_ON}; // [R10]
                    `CISC_Q_FRAC: begin
                        case (cmd_qual)
                            `CISC_QUAL_MIN: rsp_value <= {25'h0000000, `CISC_FRAC_MIN}; // [R11]
                            `CISC_QUAL_MAX: rsp_value <= {25'h0000000, `CISC_FRAC_MAX}; // [R11]
                            `CISC_QUAL_DEF: rsp_value <= {25'h0000000, `CISC_FRAC_DEF};
                            default: rsp_value <= {25'h0000000, frac[sel]};
                        endcase
                    end
                    `CISC_Q_SLOPE: rsp_value <= {31'h00000000, falling[sel]}; // [R12]
                    `CISC_Q_BAND: rsp_value <= {30'h00000000, band[sel]}; // [R14]
                    `CISC_Q_GATE: begin
                        case (cmd_qual)
                            `CISC_QUAL_MIN: rsp_value <= {15'h0000, `CISC_GATE_MIN}; // [R18]
                            `CISC_QUAL_MAX: rsp_value <= {15'h0000, `CISC_GATE_MAX}; // [R18]
                            `CISC_QUAL_DEF: rsp_value <= {15'h0000, `CISC_GATE_DEF}; // [R18]
                            default: rsp_value <= {15'h0000, gate_ms}; // [R18]
                        endcase
                    end
                    `CISC_Q_RAUTO: rsp_value <= {31'h00000000, range_auto};
                    `CISC_Q_AVG_COUNT: rsp_value <= {15'h0000, `CISC_AVG_COUNT}; // [R1]
                    default: rsp_value <= 32'h00000000;
                endcase
            end
        end
    end

    // band code to width; the comparator needs the swing to pass both limits
    function [7:0] band_mv;
        input [1:0] code;
        begin
            case (code)
                `CISC_BAND_MIN: band_mv = `CISC_BAND_MIN_MV;
                `CISC_BAND_MAX: band_mv = `CISC_BAND_MAX_MV;
                default: band_mv = `CISC_BAND_DEF_MV;
            endcase
        end
    endfunction

    // registered outputs to the comparators and gate timer
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            level_one <= `CISC_LEVEL_DEF;
            level_two <= `CISC_LEVEL_DEF;
            slope_falling_one <= 1'b0;
            slope_falling_two <= 1'b0;
            band_mv_one <= `CISC_BAND_DEF_MV;
            band_mv_two <= `CISC_BAND_DEF_MV;
            prescale_on <= 1'b0;
        end else begin
            level_one <= abs_level[0];
            level_two <= abs_level[1];
            slope_falling_one <= falling[0]; // [R12]
            slope_falling_two <= falling[1];
            band_mv_one <= band_mv(band[0]); // [R13]
            band_mv_two <= band_mv(band[1]); // [R13]
            // gate timer treats gate_ms as a minimum and closes on a period edge [R17]
            prescale_on <= range_auto && meas_func_fpr && (input_freq_hz > `CISC_PRESCALE_HZ); // [R19] [R21]
        end
    end
endmodule // cisc_setup
`default_nettype wire

// file: logic/cisc_consts.vh
// Purpose: constants for the counter input setup command block
// Assumes: levels in 2.5 mV steps (signed), gate duration in 1 ms steps
// Notes: error codes are carried as signed 16-bit values
`ifndef CISC_CONSTS_VH
`define CISC_CONSTS_VH
// command opcodes
`define CISC_OP_NOP 4'h0
`define CISC_OP_SET_LEVEL 4'h1
`define CISC_OP_SET_AUTO 4'h2
`define CISC_OP_SET_FRAC 4'h3
`define CISC_OP_SET_SLOPE 4'h4
`define CISC_OP_SET_BAND 4'h5
`define CISC_OP_SET_GATE 4'h6
`define CISC_OP_SET_RAUTO 4'h7
`define CISC_OP_SET_RANGE 4'h8
`define CISC_OP_QUERY 4'h9
`define CISC_OP_POP_ERR 4'ha
// query items
`define CISC_Q_LEVEL 4'h0
`define CISC_Q_AUTO 4'h1
`define CISC_Q_FRAC 4'h2
`define CISC_Q_SLOPE 4'h3
`define CISC_Q_BAND 4'h4
`define CISC_Q_GATE 4'h5
`define CISC_Q_RAUTO 4'h6
`define CISC_Q_AVG_COUNT 4'h7
// query qualifiers
`define CISC_QUAL_CUR 2'h0
`define CISC_QUAL_MIN 2'h1
`define CISC_QUAL_MAX 2'h2
`define CISC_QUAL_DEF 2'h3
// auto level modes
`define CISC_AUTO_OFF 2'h0
`define CISC_AUTO_ON 2'h1
`define CISC_AUTO_SINGLE_SHOT_LEVEL_FIND 2'h2
// noise band codes
`define CISC_BAND_MIN 2'h0
`define CISC_BAND_DEF 2'h1
`define CISC_BAND_MAX 2'h2
`define CISC_BAND_MIN_MV 8'h1e
`define CISC_BAND_DEF_MV 8'h3c
`define CISC_BAND_MAX_MV 8'h64
// level limits in 2.5 mV steps: +-10.2375 V = +-4095 steps
`define CISC_LEVEL_STEP_UV 2500
`define CISC_LEVEL_MAX 13'sh0fff
`define CISC_LEVEL_MIN (-13'sh0fff)
`define CISC_LEVEL_DEF 13'sh0000
// peak fraction percent
`define CISC_FRAC_MIN 7'h0a
`define CISC_FRAC_MAX 7'h5a
`define CISC_FRAC_DEF 7'h32
// gate duration in ms
`define CISC_GATE_MIN 17'h00001
`define CISC_GATE_MAX 17'h1869f
`define CISC_GATE_DEF 17'h00064
// averaging count, fixed
`define CISC_AVG_COUNT 17'h00064
// prescale threshold in Hz and divide ratio
`define CISC_PRESCALE_HZ 28'h5f5e100
`define CISC_PRESCALE_DIV 2'h2
// error code for clipped data
`define CISC_ERR_CLIPPED (-16'sd209)
`define CISC_ERR_NONE 16'sh0000
`endif

// file: logic/cisc_err_queue.v
// Purpose: first-in first-out queue of posted error codes
// Assumes: at most one push per cycle; pop on an empty queue returns no error
// Notes: a push to a full queue is dropped and the overflow flag latches
`timescale 1ns/100ps
`default_nettype none
`include "cisc_consts.vh"
module cisc_err_queue #(
    parameter DEPTH_LOG2 = 3
) (
    input wire clk, // instrument clock
    input wire reset_n, // async reset, active low
    input wire push, // post one error code
    input wire [15:0] push_code, // code being posted
    input wire pop, // take the oldest code
    output reg [15:0] pop_code, // oldest code, valid after pop
    output wire empty, // no codes waiting
    output reg overflow // a code was lost
);
    localparam DEPTH = 1 << DEPTH_LOG2;
    reg [15:0] mem [0:DEPTH-1];
    reg [DEPTH_LOG2:0] wr_ptr;
    reg [DEPTH_LOG2:0] rd_ptr;
    wire full;

    assign empty = (wr_ptr == rd_ptr);
    assign full = (wr_ptr[DEPTH_LOG2-1:0] == rd_ptr[DEPTH_LOG2-1:0]) &&
                  (wr_ptr[DEPTH_LOG2] != rd_ptr[DEPTH_LOG2]);

    // storage has no reset; only pointers define content
    always @(posedge clk) begin
        if (push && !full) begin
            mem[wr_ptr[DEPTH_LOG2-1:0]] <= push_code; // [R22]
        end
    end

    // pointer and read data; errors come out in arrival order
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_ptr <= {(DEPTH_LOG2+1){1'b0}};
            rd_ptr <= {(DEPTH_LOG2+1){1'b0}};
            pop_code <= 16'h0000;
            overflow <= 1'b0;
        end else begin
            if (push && !full) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (push && full) begin
                overflow <= 1'b1;
            end
            if (pop) begin
                if (!empty) begin
                    pop_code <= mem[rd_ptr[DEPTH_LOG2-1:0]]; // [R22]
                    rd_ptr <= rd_ptr + 1'b1;
                end else begin
                    pop_code <= `CISC_ERR_NONE;
                end
            end
        end
    end
endmodule // cisc_err_queue
`default_nettype wire

// file: tb/cisc_ctrl_model.sv
// Purpose: remote controller model sending decoded commands to the setup block
// Assumes: commands launch at the falling edge, one strobe per command
// Notes: on release cmd_value takes the inverse value so a stale value never reads as valid
`timescale 1ns/100ps
`default_nettype none
`include "cisc_consts.vh"
module cisc_ctrl_model (
    input wire logic clk, // instrument clock
    input wire logic rsp_valid, // answer strobe
    input wire logic [31:0] rsp_value, // answer value
    output logic cmd_valid, // command strobe
    output logic [3:0] cmd_op, // opcode
    output logic cmd_input, // input select
    output logic [3:0] cmd_item, // query item
    output logic [1:0] cmd_qual, // query qualifier
    output logic [31:0] cmd_value // command value
);
    // idle bus at time zero
    initial {cmd_valid, cmd_op, cmd_input, cmd_item, cmd_qual, cmd_value} = '0;
    // one command; the strobe stands for exactly one taking edge
    task automatic send(input logic [3:0] op, input logic inp, input logic [3:0] it,
                        input logic [1:0] q, input logic [31:0] v);
        @(negedge clk);
        cmd_valid = 1'b1;
        cmd_op = op;
        cmd_input = inp;
        cmd_item = it;
        cmd_qual = q;
        cmd_value = v;
        @(negedge clk);
        cmd_valid = 1'b0;
        cmd_value = ~v;
    endtask
    // query: the answer stands only in the cycle after the taking edge
    task automatic ask(input logic [3:0] it, input logic inp, input logic [1:0] q,
                       output logic ok, output logic [31:0] val);
        send(`CISC_OP_QUERY, inp, it, q, 32'h0);
        ok = rsp_valid;
        val = rsp_value;
    endtask
    // pop answers a cycle later; one idle cycle after it keeps a query visible
    task automatic pop(output logic ok, output logic [31:0] val);
        send(`CISC_OP_POP_ERR, 1'b0, 4'h0, 2'h0, 32'h0);
        @(negedge clk);
        ok = rsp_valid;
        val = rsp_value;
        @(negedge clk);
    endtask
endmodule // cisc_ctrl_model
`default_nettype wire

// file: tb/cisc_setup_asserts.sv
// Purpose: port-level checks for the input setup command block
// Assumes: outputs follow a set two edges after the taking edge
// Notes: level and gate checks assume no second set of the same item within two cycles
`timescale 1ns/100ps
`default_nettype none
`include "cisc_consts.vh"
module cisc_setup_asserts (
    input wire logic clk, // instrument clock
    input wire logic reset_n, // async reset, active low
    input wire logic cmd_valid, // command strobe
    input wire logic [3:0] cmd_op, // opcode
    input wire logic cmd_input, // input select
    input wire logic [3:0] cmd_item, // query item
    input wire logic [31:0] cmd_value, // command value
    input wire logic rsp_valid, // answer strobe
    input wire logic [31:0] rsp_value, // answer value
    input wire logic err_empty, // error queue empty
    input wire logic meas_func_fpr, // frequency, period or ratio
    input wire logic signed [12:0] level_one, // level, input one
    input wire logic [7:0] band_mv_one, // noise band, input one
    input wire logic [16:0] gate_ms, // gate duration
    input wire logic prescale_on // prescaler engaged
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    // decoded set strobes
    wire logic set_l1 = cmd_valid && cmd_op == `CISC_OP_SET_LEVEL && !cmd_input;
    wire logic set_gate = cmd_valid && cmd_op == `CISC_OP_SET_GATE;
    chk_avg_fixed: assert property (cmd_valid && cmd_op == `CISC_OP_QUERY && cmd_item == 4'h7
        |=> rsp_valid && rsp_value == 32'h64) else $error("averaging count answer wrong");
    chk_level_span: assert property (level_one <= `CISC_LEVEL_MAX && level_one >= `CISC_LEVEL_MIN)
        else $error("level outside span");
    chk_clip_high: assert property (set_l1 && $signed(cmd_value) > 32'sd10237500
        |-> ##2 level_one == `CISC_LEVEL_MAX && !err_empty) else $error("high level not clipped");
    chk_clip_low: assert property (set_l1 && $signed(cmd_value) < -32'sd10237500
        |-> ##2 level_one == `CISC_LEVEL_MIN) else $error("low level not clipped");
    chk_level_trunc: assert property (set_l1 && $signed(cmd_value) <= 32'sd10237500
        && $signed(cmd_value) >= -32'sd10237500 |-> ##2 level_one == $signed($past(cmd_value, 2)) / 2500)
        else $error("level not truncated to step");
    chk_gate_floor: assert property (set_gate && $signed(cmd_value) < 32'sd1000
        |-> ##2 gate_ms == 17'h1 && !err_empty) else $error("short gate not raised");
    chk_gate_trunc: assert property (set_gate && cmd_value >= 32'd1000 && cmd_value < 32'd100000000
        |-> ##2 {15'h0, gate_ms} == $past(cmd_value, 2) / 32'd1000) else $error("gate not truncated");
    chk_band_max: assert property (cmd_valid && cmd_op == `CISC_OP_SET_BAND && !cmd_input
        && cmd_value == 32'h2 |-> ##2 band_mv_one == 8'h64) else $error("band max not 100 mV");
    chk_pop_answer: assert property (cmd_valid && cmd_op == `CISC_OP_POP_ERR |-> ##2 rsp_valid)
        else $error("pop without answer");
    chk_prescale_fpr: assert property (!meas_func_fpr [*4] |-> !prescale_on)
        else $error("prescaler on outside fpr functions");
    chk_reset_defaults: assert property ($rose(reset_n)
        |-> level_one == 13'sh0 && gate_ms == 17'h64 && band_mv_one == 8'h3c) else $error("bad defaults");
endmodule // cisc_setup_asserts
bind cisc_setup cisc_setup_asserts i_chk (.*);
`default_nettype wire

// file: tb/tb_cisc_setup.sv
// Purpose: self-checking bench for the input setup command block
// Assumes: inputs change at the falling edge; commands go through the controller model
// Notes: outputs are read two idle cycles after each set so they have settled
`timescale 1ns/100ps
`default_nettype none
module tb_cisc_setup;
    logic clk, reset_n, cmd_valid, cmd_input, rsp_valid, err_empty, err_overflow, prescale_on;
    logic meas_start, meas_func_fpr, meas_input, slope_falling_one, slope_falling_two;
    logic [3:0] cmd_op, cmd_item;
    logic [1:0] cmd_qual;
    logic [31:0] cmd_value, rsp_value;
    logic signed [12:0] peak_neg, peak_pos, level_one, level_two;
    logic [7:0] band_mv_one, band_mv_two;
    logic [16:0] gate_ms;
    logic [27:0] input_freq_hz;
    int n_fail = 0;
    int n_checks = 0;
    int cyc = 0;
    cisc_setup i_dut (.*);
    cisc_ctrl_model i_ctrl (.*);
    // 250 MHz clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic set(input logic [3:0] op, input logic inp, input logic [31:0] v);
        i_ctrl.send(op, inp, 4'h0, 2'h0, v);
        repeat (2) @(negedge clk);
    endtask
    task automatic ask(input logic [3:0] it, input logic inp, input logic [1:0] q, input logic [31:0] exp);
        logic ok;
        logic [31:0] v;
        i_ctrl.ask(it, inp, q, ok, v);
        chk("query strobe", 32'h1, {31'h0, ok});
        chk("query value", exp, v);
    endtask
    task automatic pop(input logic [31:0] exp);
        logic ok;
        logic [31:0] v;
        i_ctrl.pop(ok, v);
        chk("pop strobe", 32'h1, {31'h0, ok});
        chk("pop value", exp, v);
    endtask
    // the level is only worked out on a measurement start
    task automatic meas;
        @(negedge clk) meas_start = 1'b1;
        @(negedge clk) meas_start = 1'b0;
        repeat (3) @(negedge clk);
    endtask
    task automatic final_report;
        $display("checks %0d failures %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // a hang costs a failure and ends the run
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            n_fail++;
            final_report;
        end
    end
    initial begin
        int bands [3] = '{30, 60, 100};
        reset_n = 1'b0;
        meas_start = 1'b0;
        meas_func_fpr = 1'b0;
        meas_input = 1'b0;
        peak_neg = 13'sh0;
        peak_pos = 13'sh0;
        input_freq_hz = 28'h0;
        repeat (10) @(posedge clk);
        @(negedge clk) reset_n = 1'b1;
        chk("level_one", 0, level_one);
        chk("level_two", 0, level_two);
        chk("slope", 0, {slope_falling_one, slope_falling_two});
        chk("gate", 100, gate_ms);
        chk("band_two", 60, band_mv_two);
        ask(4'h7, 1'b0, 2'h0, 100);
        ask(4'h2, 1'b0, 2'h1, 10);
        ask(4'h2, 1'b0, 2'h2, 90);
        ask(4'h2, 1'b0, 2'h3, 50);
        ask(4'h5, 1'b0, 2'h1, 1);
        ask(4'h5, 1'b0, 2'h2, 99999);
        ask(4'h5, 1'b0, 2'h3, 100);
        set(4'h1, 1'b0, 1001000);
        chk("level_one", 400, level_one);
        set(4'h1, 1'b1, -1001000);
        chk("level_two", -400, level_two);
        ask(4'h0, 1'b0, 2'h0, 400);
        set(4'h1, 1'b0, 20000000);
        chk("level_one", 4095, level_one);
        set(4'h1, 1'b1, -20000000);
        chk("level_two", -4095, level_two);
        set(4'h3, 1'b0, 75);
        set(4'h2, 1'b0, 1);
        ask(4'h1, 1'b0, 2'h0, 1);
        peak_neg = -13'sd100;
        peak_pos = 13'sd300;
        repeat (4) @(negedge clk);
        chk("level_one", 4095, level_one);
        meas;
        chk("level_one", 200, level_one);
        set(4'h1, 1'b0, 0);
        ask(4'h1, 1'b0, 2'h0, 0);
        chk("level_one", 0, level_one);
        set(4'h2, 1'b0, 2);
        ask(4'h1, 1'b0, 2'h0, 0);
        meas;
        chk("level_one", 200, level_one);
        peak_neg = 13'sd0;
        peak_pos = 13'sd400;
        meas;
        chk("level_one", 200, level_one);
        set(4'h4, 1'b1, 1);
        chk("slope", 1, {slope_falling_one, slope_falling_two});
        ask(4'h3, 1'b1, 2'h0, 1);
        for (int b = 0; b < 3; b++) begin
            set(4'h5, 1'b0, b);
            chk("band", bands[b], band_mv_one);
            ask(4'h4, 1'b0, 2'h0, b);
        end
        set(4'h6, 1'b0, 256999);
        ask(4'h5, 1'b0, 2'h0, 256);
        set(4'h6, 1'b0, 0);
        chk("gate", 1, gate_ms);
        set(4'h6, 1'b0, 200000000);
        chk("gate", 99999, gate_ms);
        meas_func_fpr = 1'b1;
        input_freq_hz = 28'd100000001;
        set(4'h7, 1'b0, 1);
        repeat (2) @(negedge clk);
        chk("prescale", 1, prescale_on);
        input_freq_hz = 28'd100000000;
        repeat (4) @(negedge clk);
        chk("prescale", 0, prescale_on);
        input_freq_hz = 28'd150000000;
        meas_func_fpr = 1'b0;
        repeat (6) @(negedge clk);
        chk("prescale", 0, prescale_on);
        meas_func_fpr = 1'b1;
        set(4'h8, 1'b0, 1);
        ask(4'h6, 1'b0, 2'h0, 0);
        // four clips so far; five more overflow the eight-deep queue
        repeat (5) set(4'h6, 1'b0, 0);
        chk("overflow", 1, err_overflow);
        repeat (8) pop(-209);
        chk("empty", 1, err_empty);
        pop(0);
        final_report;
    end
endmodule // tb_cisc_setup
`default_nettype wire
